// >>> logic/ppc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

// clock
`define PPC_CLK_NS          10
// register offsets
`define PPC_ADDR_WAIT       8'h83
`define PPC_ADDR_INTERRUPT_PERSISTENCE       8'h8c
`define PPC_ADDR_WCFG       8'h8d
`define PPC_ADDR_PULSE      8'h8e
`define PPC_ADDR_CTRL       8'h8f
// reset values
`define PPC_RST_WAIT        8'hff
`define PPC_RST_INTERRUPT_PERSISTENCE        8'h00
`define PPC_RST_WCFG        8'h60
`define PPC_RST_PULSE       8'h00
`define PPC_RST_CTRL        8'h00
`define PPC_RD_UNMAPPED     8'h00
// field positions
`define PPC_WCFG_STRETCH    1
`define PPC_WCFG_LOWPWR     5
`define PPC_WCFG_KEEP1      6
`define PPC_CTRL_ROUTE      5
`define PPC_CTRL_INVERT     4
// persistence codes and steps
`define PPC_INTERRUPT_PERSISTENCE_EVERY      4'h0
`define PPC_INTERRUPT_PERSISTENCE_DIRECT_MAX 4'h3
`define PPC_INTERRUPT_PERSISTENCE_STEP       6'h05
`define PPC_INTERRUPT_PERSISTENCE_STEP_BASE  4'h3
`define PPC_CNT_MAX         6'h3f
// wait timing
`define PPC_WAIT_UNIT_NS    2780000
`define PPC_WAIT_UNIT_CYC   ((`PPC_WAIT_UNIT_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_WAIT_FULL       9'h100
`define PPC_WAIT_MULT_LONG  4'hc
`define PPC_WAIT_MULT_SHORT 4'h1
// proximity pulse timing
`define PPC_PLEN_BASE_NS    4000
`define PPC_PLEN_BASE_CYC   ((`PPC_PLEN_BASE_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_LED_EXTRA_NS    1360
`define PPC_LED_EXTRA_CYC   ((`PPC_LED_EXTRA_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_PULSE_GAP_NS    1000
`define PPC_PULSE_GAP_CYC   ((`PPC_PULSE_GAP_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)

`endif

// >>> logic/ppc_pkg.sv
// types shared by the pulse and persistence controller
`default_nettype none
package ppc_pkg;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ppc_reg_req_t;

  // per-pulse analog settings
  typedef struct packed {
    logic [1:0] led_current_scale;
    logic [1:0] prox_gain_sel;
    logic [1:0] color_gain_sel;
    logic [1:0] prox_pulse_width;
  } ppc_analog_t;

  typedef enum logic [1:0] {
    PG_IDLE  = 2'b00,
    PG_LEAD  = 2'b01,
    PG_INTEG = 2'b10,
    PG_GAP   = 2'b11
  } ppc_pg_state_t;

endpackage
`default_nettype wire

// >>> logic/ppc_ctrl.sv
// persistence filter, wait timer, proximity pulse generator and led routing
`include "ppc_map.svh"
`default_nettype none

// Function
// - light persistence code 0000 raises the clear interrupt after every light cycle.
// - code 0001 raises the clear interrupt on any single out-of-range result.
// - codes 0010 and 0011 need two and three consecutive out-of-range results.
// - light codes 0100 to 1111 need 5 to 60 consecutive results, steps of five; proximity codes 0100 to 1111 need 4 to 15.
// - separate proximity and light counters; an in-range result clears its counter.
// - wait stretch bit multiplies every wait period by twelve.
// - wait period counts 256 minus wait value units of 2.78 ms.
// - reserved config bit 6 resets to one; host keeps writing one.
// - config bit 5 resets to one; clearing it disables low-power wait.
// - pulse width code 00 to 11 selects 4, 8, 16 or 32 us integration.
// - pulses per cycle equal the six-bit pulse count plus one.
// - led stays on about 1.36 us longer than the integration window.
// - led drive code scales current to 100, 50, 25 or 12.5 percent.
// - control bit 5 routes the led pulse pattern onto the interrupt pin.
// - with routing on, control bit 4 inverts the interrupt pin pattern.
// - proximity gain 1x to 8x in bits 3:2, colour gain 1x to 64x in 1:0.
module ppc_ctrl import ppc_pkg::*; #(
  parameter int unsigned WAIT_UNIT_CYCLES = `PPC_WAIT_UNIT_CYC
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // register port
  input  wire ppc_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  output logic              reg_rvalid,
  // conversion results
  input  wire logic         als_valid,
  input  wire logic         als_out_of_range,
  input  wire logic         als_irq_clear,
  input  wire logic         prox_valid,
  input  wire logic         prox_out_of_range,
  input  wire logic         prox_irq_clear,
  // sequencer requests
  input  wire logic         wait_start,
  input  wire logic         prox_start,
  output logic              wait_busy,
  output logic              wait_done,
  output logic              prox_busy,
  output logic              prox_done,
  // analog and pins
  output ppc_analog_t       analog_cfg,
  output logic              wait_lowpower,
  output logic              led_sink_pin,
  output logic              prox_integrate,
  output logic              als_irq,
  output logic              prox_irq,
  output logic              irq_pin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]    wait_period_value;
    logic [7:0]    persist_setting;
    logic [7:0]    wait_extend_config;
    logic [7:0]    prox_pulse_setup;
    logic [7:0]    led_gain_control;
    logic [7:0]    rdata;
    logic          rvalid;
    logic [5:0]    als_cnt;
    logic [5:0]    prox_cnt;
    logic          als_irq;
    logic          prox_irq;
    logic          wait_busy;
    logic          wait_done;
    logic [19:0]   wait_tick;
    logic [11:0]   wait_left;
    ppc_pg_state_t pg_state;
    logic [15:0]   pg_cnt;
    logic [15:0]   pg_width;
    logic [5:0]    pulses_left;
    logic          prox_done;
    ppc_analog_t   ana;
  } ppc_state_t;

  ppc_state_t st_q;
  ppc_state_t st_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // consecutive out-of-range results needed for a persistence code
  function automatic logic [5:0] interrupt_persistence_limit(input logic [3:0] code);
    logic [5:0] lim;
    lim = {2'b00, code};
    if (code > `PPC_INTERRUPT_PERSISTENCE_DIRECT_MAX) begin
      lim = 6'((code - `PPC_INTERRUPT_PERSISTENCE_STEP_BASE) * `PPC_INTERRUPT_PERSISTENCE_STEP);
    end
    return lim;
  endfunction

  // next counter value and fire flag; proximity codes count results one for one
  function automatic logic [6:0] interrupt_persistence_step(input logic [5:0] cnt, input logic oor,
                                           input logic [3:0] code, input logic direct);
    logic [5:0] nxt;
    logic       fire;
    nxt  = 6'h00;
    fire = 1'b0;
    if (oor) begin
      nxt = (cnt == `PPC_CNT_MAX) ? cnt : cnt + 6'h01;
    end
    if (code == `PPC_INTERRUPT_PERSISTENCE_EVERY) begin
      fire = 1'b1;
    end else if (oor && nxt >= (direct ? {2'b00, code} : interrupt_persistence_limit(code))) begin
      fire = 1'b1;
    end
    return {fire, nxt};
  endfunction

  // integration width in cycles; 4 us doubled per code step
  function automatic logic [15:0] width_cycles(input logic [1:0] code);
    logic [15:0] base;
    base = 16'(`PPC_PLEN_BASE_CYC);
    return base << code;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [6:0] als_r;
    logic [6:0] prox_r;
    logic [3:0] mult;
    als_r  = 7'h00;
    prox_r = 7'h00;
    mult   = `PPC_WAIT_MULT_SHORT;
    st_d   = st_q;
    st_d.rvalid    = 1'b0;
    st_d.wait_done = 1'b0;
    st_d.prox_done = 1'b0;
    // register writes; reserved bits stored as written, host keeps them
    if (reg_req.wr) begin
      if (reg_req.addr == `PPC_ADDR_WAIT) begin
        st_d.wait_period_value = reg_req.wdata;
      end else if (reg_req.addr == `PPC_ADDR_INTERRUPT_PERSISTENCE) begin
        st_d.persist_setting = reg_req.wdata;
      end else if (reg_req.addr == `PPC_ADDR_WCFG) begin
        st_d.wait_extend_config = reg_req.wdata;
      end else if (reg_req.addr == `PPC_ADDR_PULSE) begin
        st_d.prox_pulse_setup = reg_req.wdata;
      end else if (reg_req.addr == `PPC_ADDR_CTRL) begin
        st_d.led_gain_control = reg_req.wdata;
      end
    end
    // register reads answer one cycle later
    if (reg_req.rd) begin
      st_d.rvalid = 1'b1;
      if (reg_req.addr == `PPC_ADDR_WAIT) begin
        st_d.rdata = st_q.wait_period_value;
      end else if (reg_req.addr == `PPC_ADDR_INTERRUPT_PERSISTENCE) begin
        st_d.rdata = st_q.persist_setting;
      end else if (reg_req.addr == `PPC_ADDR_WCFG) begin
        st_d.rdata = st_q.wait_extend_config;
      end else if (reg_req.addr == `PPC_ADDR_PULSE) begin
        st_d.rdata = st_q.prox_pulse_setup;
      end else if (reg_req.addr == `PPC_ADDR_CTRL) begin
        st_d.rdata = st_q.led_gain_control;
      end else begin
        st_d.rdata = `PPC_RD_UNMAPPED;
      end
    end
    // persistence filters; a new event wins over a clear in the same cycle
    if (als_irq_clear) begin
      st_d.als_irq = 1'b0;
    end
    if (prox_irq_clear) begin
      st_d.prox_irq = 1'b0;
    end
    if (als_valid) begin
      als_r = interrupt_persistence_step(st_q.als_cnt, als_out_of_range, st_q.persist_setting[3:0], 1'b0);
      st_d.als_cnt = als_r[5:0];
      if (als_r[6]) begin
        st_d.als_irq = 1'b1;
      end
    end
    if (prox_valid) begin
      prox_r = interrupt_persistence_step(st_q.prox_cnt, prox_out_of_range, st_q.persist_setting[7:4], 1'b1);
      st_d.prox_cnt = prox_r[5:0];
      if (prox_r[6]) begin
        st_d.prox_irq = 1'b1;
      end
    end
    // wait timer: total units = (256 - value) times 1 or 12
    if (st_q.wait_extend_config[`PPC_WCFG_STRETCH]) begin
      mult = `PPC_WAIT_MULT_LONG;
    end
    if (!st_q.wait_busy) begin
      if (wait_start) begin
        st_d.wait_busy = 1'b1;
        st_d.wait_tick = 20'h00000;
        st_d.wait_left = 12'(mult)
                         * (12'(`PPC_WAIT_FULL) - {4'h0, st_q.wait_period_value});
      end
    end else if (st_q.wait_tick == 20'(WAIT_UNIT_CYCLES - 1)) begin
      st_d.wait_tick = 20'h00000;
      st_d.wait_left = st_q.wait_left - 12'h001;
      if (st_q.wait_left == 12'h001) begin
        st_d.wait_busy = 1'b0;
        st_d.wait_done = 1'b1;
      end
    end else begin
      st_d.wait_tick = st_q.wait_tick + 20'h00001;
    end
    // pulse generator: lead (led only), integrate, gap, repeat
    case (st_q.pg_state)
      PG_IDLE: begin
        if (prox_start) begin
          st_d.pulses_left = st_q.prox_pulse_setup[5:0];
          st_d.pg_state    = PG_LEAD;
          st_d.pg_cnt      = 16'h0000;
          st_d.pg_width    = width_cycles(st_q.prox_pulse_setup[7:6]);
          st_d.ana         = {st_q.led_gain_control[7:6], st_q.led_gain_control[3:2],
                              st_q.led_gain_control[1:0], st_q.prox_pulse_setup[7:6]};
        end
      end
      PG_LEAD: begin
        st_d.pg_cnt = st_q.pg_cnt + 16'h0001;
        if (st_q.pg_cnt == 16'(`PPC_LED_EXTRA_CYC - 1)) begin
          st_d.pg_state = PG_INTEG;
          st_d.pg_cnt   = 16'h0000;
        end
      end
      PG_INTEG: begin
        st_d.pg_cnt = st_q.pg_cnt + 16'h0001;
        if (st_q.pg_cnt == st_q.pg_width - 16'h0001) begin
          st_d.pg_cnt = 16'h0000;
          if (st_q.pulses_left == 6'h00) begin
            st_d.pg_state  = PG_IDLE;
            st_d.prox_done = 1'b1;
          end else begin
            st_d.pg_state = PG_GAP;
          end
        end
      end
      PG_GAP: begin
        st_d.pg_cnt = st_q.pg_cnt + 16'h0001;
        if (st_q.pg_cnt == 16'(`PPC_PULSE_GAP_CYC - 1)) begin
          // next pulse follows at once with freshly sampled settings
          st_d.pg_state    = PG_LEAD;
          st_d.pg_cnt      = 16'h0000;
          st_d.pulses_left = st_q.pulses_left - 6'h01;
          st_d.pg_width    = width_cycles(st_q.prox_pulse_setup[7:6]);
          st_d.ana         = {st_q.led_gain_control[7:6], st_q.led_gain_control[3:2],
                              st_q.led_gain_control[1:0], st_q.prox_pulse_setup[7:6]};
        end
      end
      default: begin
        st_d.pg_state = PG_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q                    <= '0;
      st_q.wait_period_value  <= `PPC_RST_WAIT;
      st_q.persist_setting    <= `PPC_RST_INTERRUPT_PERSISTENCE;
      st_q.wait_extend_config <= `PPC_RST_WCFG;
      st_q.prox_pulse_setup   <= `PPC_RST_PULSE;
      st_q.led_gain_control   <= `PPC_RST_CTRL;
      st_q.pg_state           <= PG_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // led covers both lead and integration so integration sits inside it
  assign led_sink_pin   = (st_q.pg_state == PG_LEAD) || (st_q.pg_state == PG_INTEG);
  assign prox_integrate = (st_q.pg_state == PG_INTEG);
  assign prox_busy      = (st_q.pg_state != PG_IDLE);
  assign prox_done      = st_q.prox_done;
  assign analog_cfg     = st_q.ana;
  assign wait_busy      = st_q.wait_busy;
  assign wait_done      = st_q.wait_done;
  assign wait_lowpower  = st_q.wait_extend_config[`PPC_WCFG_LOWPWR];
  assign als_irq        = st_q.als_irq;
  assign prox_irq       = st_q.prox_irq;
  assign reg_rdata      = st_q.rdata;
  assign reg_rvalid     = st_q.rvalid;

  // routed pattern replaces the normal interrupt level on the pin
  assign irq_pin = st_q.led_gain_control[`PPC_CTRL_ROUTE]
                 ? led_sink_pin ^ st_q.led_gain_control[`PPC_CTRL_INVERT]
                 : st_q.als_irq | st_q.prox_irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // pulses seen in the current proximity cycle
  logic [6:0] pulse_seen_q;
  always_ff @(posedge clk) begin
    if (sys_rst || prox_start && !prox_busy) begin
      pulse_seen_q <= 7'h00;
    end else if (st_q.pg_state == PG_LEAD && st_q.pg_cnt == 16'h0000) begin
      pulse_seen_q <= pulse_seen_q + 7'h01;
    end
  end

  property p_every;
    als_valid && st_q.persist_setting[3:0] == 4'h0 |=> als_irq;
  endproperty
  a_every: assert property (p_every) else $error("code 0 missed interrupt");
  property p_any;
    als_valid && als_out_of_range && st_q.persist_setting[3:0] == 4'h1 |=> als_irq;
  endproperty
  a_any: assert property (p_any) else $error("code 1 missed interrupt");
  property p_three;
    als_valid && als_out_of_range && st_q.persist_setting[3:0] == 4'h3 && !als_irq
      && st_q.als_cnt == 6'h01 && !als_irq_clear |=> !als_irq ##0 st_q.als_cnt == 6'h02;
  endproperty
  a_three: assert property (p_three) else $error("code 3 fired early");
  property p_five;
    als_valid && als_out_of_range && st_q.persist_setting[3:0] == 4'h4
      && st_q.als_cnt == 6'h04 |=> als_irq;
  endproperty
  a_five: assert property (p_five) else $error("code 4 missed fifth");
  property p_reset_cnt;
    prox_valid && !prox_out_of_range |=> st_q.prox_cnt == 6'h00;
  endproperty
  a_reset_cnt: assert property (p_reset_cnt) else $error("in-range kept count");
  property p_wait_len;
    wait_start && !wait_busy |=> st_q.wait_left
      == 12'(($past(st_q.wait_extend_config[1]) ? 12 : 1)
      * (256 - $past(st_q.wait_period_value)));
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("wrong wait length");
  property p_por_bits;
    $fell(sys_rst) |-> st_q.wait_extend_config[6] && st_q.wait_extend_config[5];
  endproperty
  a_por_bits: assert property (p_por_bits) else $error("reserved bits not one");
  property p_lead;
    $rose(led_sink_pin) |-> !prox_integrate [*8];
  endproperty
  a_lead: assert property (p_lead) else $error("integration before led lead");
  property p_width;
    $rose(prox_integrate) |-> st_q.pg_width == 16'(400 << st_q.ana.prox_pulse_width);
  endproperty
  a_width: assert property (p_width) else $error("wrong pulse width");
  property p_count;
    prox_done |-> pulse_seen_q == {1'b0, $past(st_q.prox_pulse_setup[5:0])} + 7'h01;
  endproperty
  a_count: assert property (p_count) else $error("wrong pulse count");
  property p_route;
    st_q.led_gain_control[5] |-> irq_pin == (led_sink_pin ^ st_q.led_gain_control[4]);
  endproperty
  a_route: assert property (p_route) else $error("routed pin wrong");

endmodule
`default_nettype wire

// >>> tb/ppc_res_src.sv
// conversion result source standing in for the light and proximity engines
`default_nettype none

module ppc_res_src (
  // clock
  input  wire logic clk,
  // light and proximity results
  output logic      als_valid,
  output logic      als_out_of_range,
  output logic      prox_valid,
  output logic      prox_out_of_range
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // idle state
  // ----------------------------------------
  initial begin
    als_valid         = 1'b0;
    als_out_of_range  = 1'b0;
    prox_valid        = 1'b0;
    prox_out_of_range = 1'b0;
  end

  // ----------------------------------------
  // one result per call
  // ----------------------------------------
  // separate strobes per engine
  // range flag flips after the strobe so a stale value never looks valid
  task automatic send(input bit is_prox, input bit oor);
    @(posedge clk);
    #1;
    prox_valid        = is_prox;
    als_valid         = !is_prox;
    prox_out_of_range = oor;
    als_out_of_range  = oor;
    @(posedge clk);
    #1;
    prox_valid        = 1'b0;
    als_valid         = 1'b0;
    prox_out_of_range = !oor;
    als_out_of_range  = !oor;
  endtask
endmodule

`default_nettype wire

// >>> tb/tb.sv
// self-checking bench: registers, persistence, wait timer, pulse train
`include "ppc_map.svh"
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module tb import ppc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int U = 10;  // short wait unit keeps the run brief

  logic         clk;
  logic         sys_rst;
  ppc_reg_req_t reg_req;
  logic [7:0]   reg_rdata;
  logic         reg_rvalid;
  logic         als_valid, als_oor, als_irq_clear;
  logic         prox_valid, prox_oor, prox_irq_clear;
  logic         wait_start, prox_start;
  logic         wait_busy, wait_done, prox_busy, prox_done;
  ppc_analog_t  analog_cfg;
  logic         wait_lowpower, led_sink_pin, prox_integrate;
  logic         als_irq, prox_irq, irq_pin;
  int           error_cnt;
  int           n_checks;

  ppc_ctrl #(.WAIT_UNIT_CYCLES(U)) dut (
    .clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .als_valid(als_valid), .als_out_of_range(als_oor),
    .als_irq_clear(als_irq_clear), .prox_valid(prox_valid),
    .prox_out_of_range(prox_oor), .prox_irq_clear(prox_irq_clear),
    .wait_start(wait_start), .prox_start(prox_start), .wait_busy(wait_busy),
    .wait_done(wait_done), .prox_busy(prox_busy), .prox_done(prox_done),
    .analog_cfg(analog_cfg), .wait_lowpower(wait_lowpower),
    .led_sink_pin(led_sink_pin), .prox_integrate(prox_integrate),
    .als_irq(als_irq), .prox_irq(prox_irq), .irq_pin(irq_pin));

  ppc_res_src src (
    .clk(clk), .als_valid(als_valid), .als_out_of_range(als_oor),
    .prox_valid(prox_valid), .prox_out_of_range(prox_oor));

  // ----------------------------------------
  // clock and bus tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // each task starts on a fresh edge so no strobe is set twice per step
  task automatic pulse_in(ref logic s);
    @(posedge clk);
    #1;
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    reg_req.wr = 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1;
    reg_req.rd = 1'b0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, exp)
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // cycles from start edge to done pulse
  task automatic wait_run(input int exp);
    int n;
    n = 1;  // the cycle that carries the start strobe counts as the first
    pulse_in(wait_start);
    while (wait_done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, exp)
    `CHK(wait_busy, 1'b0)
  endtask

  // one pulse train, watched cycle by cycle
  task automatic train(input int i);
    int led_n, int_n, rise, n, w;
    logic prev;
    led_n = 0;
    int_n = 0;
    rise = 0;
    n = 0;
    prev = 1'b0;
    w = `PPC_PLEN_BASE_CYC << i;
    wr(`PPC_ADDR_PULSE, {i[1:0], 6'(i)});
    wr(`PPC_ADDR_CTRL, {i[1:0], i != 0, i == 3, 2'(3 - i), i[1:0]});
    pulse_in(prox_start);
    while (prox_done !== 1'b1 && n < 20000) begin
      `CHK(prox_busy, 1'b1)
      `CHK(analog_cfg, {i[1:0], 2'(3 - i), i[1:0], i[1:0]})
      `CHK(irq_pin, (i != 0) ? (led_sink_pin ^ (i == 3)) : 1'b0)
      led_n += led_sink_pin;
      int_n += prox_integrate;
      rise += (led_sink_pin && !prev);
      prev = led_sink_pin;
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(rise, i + 1)
    `CHK(int_n, (i + 1) * w)
    `CHK(led_n, (i + 1) * (w + `PPC_LED_EXTRA_CYC))
  endtask

  function automatic int lim(input int c);
    return (c <= 3) ? c : (c - 3) * 5;
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    error_cnt = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    reg_req = '0;
    als_irq_clear = 1'b0;
    prox_irq_clear = 1'b0;
    wait_start = 1'b0;
    prox_start = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    // reset values and an unmapped read
    `CHK(wait_lowpower, 1'b1)
    rdc(`PPC_ADDR_WAIT, 8'hff);
    rdc(`PPC_ADDR_INTERRUPT_PERSISTENCE, 8'h00);
    rdc(`PPC_ADDR_WCFG, 8'h60);
    rdc(`PPC_ADDR_PULSE, 8'h00);
    rdc(`PPC_ADDR_CTRL, 8'h00);
    rdc(8'h90, `PPC_RD_UNMAPPED);
    wr(8'h90, 8'h5a);
    rdc(8'h90, `PPC_RD_UNMAPPED);
    // low-power wait follows bit 5
    wr(`PPC_ADDR_WCFG, 8'h40);
    @(posedge clk);
    #1;
    `CHK(wait_lowpower, 1'b0)
    // wait timer, short and stretched
    wr(`PPC_ADDR_WCFG, 8'h60);
    wait_run(U + 1);
    wr(`PPC_ADDR_WAIT, 8'hfe);
    wr(`PPC_ADDR_WCFG, 8'h62);
    rdc(`PPC_ADDR_WCFG, 8'h62);
    wait_run(24 * U + 1);
    // light persistence over every code
    for (int c = 0; c < 16; c++) begin
      wr(`PPC_ADDR_INTERRUPT_PERSISTENCE, 8'(c));
      src.send(1'b0, 1'b0);
      if (c == 0) begin
        `CHK(als_irq, 1'b1)
      end else begin
        pulse_in(als_irq_clear);
        `CHK(als_irq, 1'b0)
        repeat (lim(c) - 1) src.send(1'b0, 1'b1);
        `CHK(als_irq, 1'b0)
        src.send(1'b0, 1'b1);
        `CHK(als_irq, 1'b1)
      end
      `CHK(irq_pin, 1'b1)
      pulse_in(als_irq_clear);
      `CHK(als_irq, 1'b0)
    end
    // proximity counter reset and independence from the light counter
    wr(`PPC_ADDR_INTERRUPT_PERSISTENCE, 8'h32);
    src.send(1'b1, 1'b0);
    pulse_in(prox_irq_clear);
    src.send(1'b1, 1'b1);
    src.send(1'b1, 1'b1);
    src.send(1'b1, 1'b0);
    src.send(1'b1, 1'b1);
    src.send(1'b1, 1'b1);
    src.send(1'b0, 1'b0);
    `CHK(prox_irq, 1'b0)
    `CHK(irq_pin, 1'b0)
    src.send(1'b1, 1'b1);
    `CHK(prox_irq, 1'b1)
    `CHK(als_irq, 1'b0)
    pulse_in(prox_irq_clear);
    // proximity code 4 needs four results, not five
    wr(`PPC_ADDR_INTERRUPT_PERSISTENCE, 8'h42);
    src.send(1'b1, 1'b0);
    repeat (3) src.send(1'b1, 1'b1);
    `CHK(prox_irq, 1'b0)
    src.send(1'b1, 1'b1);
    `CHK(prox_irq, 1'b1)
    pulse_in(prox_irq_clear);
    // pulse trains over all width, drive and gain codes
    for (int i = 0; i < 4; i++) train(i);
    print_verdict();
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // planned run is about 23k cycles; give up at 50k
  initial begin
    #500000;
    error_cnt++;
    print_verdict();
  end
endmodule

`default_nettype wire
